// *** include/mtos_map.svh ***
// special-function addresses, field positions, reset values and counts
// assumes an 8-bit special-function bus with one-cycle read and write strobes
`ifndef MTOS_MAP_SVH
`define MTOS_MAP_SVH

`define MTOS_ADDR_CONF      8'hc3
`define MTOS_ADDR_OVF_LOW   8'ha1
`define MTOS_ADDR_OVF_MID   8'ha2
`define MTOS_ADDR_OVF_HIGH  8'ha3
`define MTOS_ADDR_CMP_VAL   8'h94
`define MTOS_ADDR_OCMP_LOW  8'h9c
`define MTOS_ADDR_OCMP_MID  8'h9d
`define MTOS_ADDR_OCMP_HIGH 8'h9e

`define MTOS_CONF_CMP_FLAG  7
`define MTOS_CONF_OVF_FLAG  6
`define MTOS_CONF_OCMP_FLAG 5
`define MTOS_CONF_ZERO      4
`define MTOS_CONF_CMP_SEL   3
`define MTOS_CONF_RSVD      2
`define MTOS_CONF_SYNC      1
`define MTOS_CONF_RUN       0
`define MTOS_CONF_RESET     8'h02

`define MTOS_MASK_CMP       7
`define MTOS_MASK_OVF       6
`define MTOS_MASK_OCMP      5
`define MTOS_MASKS_RESET    3'h0

`define MTOS_SYNC_CYCLES    75
`define MTOS_RATIO_NUM      15625
`define MTOS_RATIO_SHIFT    4
`define MTOS_SLEEP_W        24
`define MTOS_CALC_W         34

`endif

// *** include/mtos_pkg.sv ***
// types shared by the overflow/sync timer block
// assumes mtos_map.svh is compiled alongside
package mtos_pkg;
	typedef logic [7:0]  mtos_byte_t;
	typedef logic [15:0] mtos_tval_t;
	typedef logic [19:0] mtos_ovf_t;
	typedef logic [23:0] mtos_sleep_t;
	typedef enum logic [2:0] {
		st_idle,
		st_run,
		st_stop_wait,
		st_start_wait,
		st_calc
	} mtos_state_t;
endpackage

// *** include/mtos_tmr_if.sv ***
// carrier between the control block and the 16-bit counter core
// assumes both ends share one clock
interface mtos_tmr_if;
	import mtos_pkg::*;
	logic       run;
	logic       halt;
	logic       load;
	mtos_tval_t load_value;
	mtos_tval_t period;
	mtos_byte_t cmp_value;
	logic       cmp_sel;
	mtos_tval_t value;
	logic       ovf_evt;
	logic       cmp_evt;
	modport ctrl (output run, halt, load, load_value, period, cmp_value, cmp_sel,
		input value, ovf_evt, cmp_evt);
	modport core (input run, halt, load, load_value, period, cmp_value, cmp_sel,
		output value, ovf_evt, cmp_evt);
endinterface

// *** src/mtos_counter.sv ***
// 16-bit up-counter with period wrap and byte compare
// assumes the controller holds load only while the counter may be overwritten
module mtos_counter
	import mtos_pkg::*;
(
	input  wire logic clk,
	input  wire logic resetn,
	mtos_tmr_if.core  tmr
);
	logic [16:0] next_count;
	logic        step;

	function automatic logic byte_ge(input logic [15:0] v, input logic sel,
		input logic [7:0] c);
		byte_ge = sel ? (v[7:0] >= c) : (v[15:8] >= c);
	endfunction

	assign next_count = {1'b0, tmr.value} + 17'h00001;
	assign step = tmr.run && !tmr.halt && !tmr.load;
	// overflow when the coming count reaches the period
	assign tmr.ovf_evt = step && (next_count >= {1'b0, tmr.period});
	// crossing only, so a count parked above the value fires once
	assign tmr.cmp_evt = step
		&& byte_ge(next_count[15:0], tmr.cmp_sel, tmr.cmp_value)
		&& !byte_ge(tmr.value, tmr.cmp_sel, tmr.cmp_value);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			tmr.value <= 16'h0000;
		else if (tmr.load)
			tmr.value <= tmr.load_value;
		else if (tmr.ovf_evt)
			tmr.value <= 16'(next_count - {1'b0, tmr.period});
		else if (step)
			tmr.value <= next_count[15:0];
	end
endmodule // mtos_counter

// *** src/mtos_top.sv ***
// overflow count, flags, dma triggers and sleep-clock synchronised start/stop
// assumes a cpu special-function bus, period and halt from the delta/capture logic
`include "mtos_map.svh"

module mtos_top
	import mtos_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic [7:0]         sfr_addr,
	input  wire mtos_pkg::mtos_byte_t sfr_wdata,
	input  wire logic               sfr_wr,
	input  wire logic               sfr_rd,
	output mtos_pkg::mtos_byte_t    sfr_rdata,
	input  wire mtos_pkg::mtos_tval_t timer_period,
	input  wire logic               count_halt,
	input  wire logic               sleep_clk,
	input  wire mtos_pkg::mtos_sleep_t sleep_count,
	output mtos_pkg::mtos_tval_t    timer_value,
	output logic                    timer_running,
	output logic                    timer_irq,
	output logic                    dma_trigger_compare,
	output logic                    dma_trigger_overflow
);
	import mtos_pkg::*;

	localparam int CALC_W = `MTOS_CALC_W;
	localparam int SLEEP_W = `MTOS_SLEEP_W;
	localparam logic [6:0] SYNC_LAST = 7'(`MTOS_SYNC_CYCLES - 1);
	localparam logic [5:0] DIV_STEPS = 6'(`MTOS_CALC_W);

	mtos_tmr_if tmr ();

	mtos_state_t state;
	logic        compare_byte_select;
	logic        sync_mode;
	logic        conf_rsvd;
	logic        compare_flag;
	logic        overflow_flag;
	logic        ovf_compare_flag;
	logic        mask_cmp;
	logic        mask_ovf;
	logic        ovf_compare_mask;
	mtos_byte_t  byte_compare_value;
	mtos_ovf_t   ovf_count;
	mtos_ovf_t   ovf_extra;
	logic        extra_pending;
	mtos_byte_t  stage_low;
	mtos_byte_t  stage_mid;
	logic [11:0] ovf_latch;
	mtos_ovf_t   ovf_compare;
	logic        ovf_ge_q;
	logic        ovf_cmp_evt;
	mtos_sleep_t sleep_stored;
	logic        sleep_ff1;
	logic        sleep_ff2;
	logic        sleep_ff3;
	logic        sleep_edge;
	logic [6:0]  calc_cnt;
	logic [5:0]  div_cnt;
	logic [CALC_W-1:0] div_quo;
	logic [16:0] div_rem;
	logic [16:0] div_shift;
	logic        load_now;
	logic        wr_conf;
	logic        wr_ovf_low;
	logic        wr_ovf_mid;
	logic        wr_ovf_high;
	logic        run_wr;
	logic        sync_wr;
	mtos_ovf_t   ovf_wval;

	// elapsed ticks, zero or negative wraps by a full sleep period
	function automatic logic [SLEEP_W:0] elapsed(input mtos_sleep_t cur,
		input mtos_sleep_t stored);
		logic [SLEEP_W-1:0] diff;
		diff = cur - stored;
		elapsed = (diff == '0) ? {1'b1, {SLEEP_W{1'b0}}} : {1'b0, diff};
	endfunction

	// ticks times 976.5625 plus timer plus overhead, rounded
	function automatic logic [CALC_W-1:0] reload_sum(input logic [SLEEP_W:0] nd,
		input mtos_tval_t tc);
		logic [CALC_W+`MTOS_RATIO_SHIFT-1:0] acc;
		acc = (CALC_W + `MTOS_RATIO_SHIFT)'(nd) * 38'(`MTOS_RATIO_NUM);
		acc = acc + ((38'(tc) + 38'(`MTOS_SYNC_CYCLES)) << `MTOS_RATIO_SHIFT);
		acc = acc + 38'(1 << (`MTOS_RATIO_SHIFT - 1));
		reload_sum = acc[CALC_W+`MTOS_RATIO_SHIFT-1:`MTOS_RATIO_SHIFT];
	endfunction

	assign wr_conf     = sfr_wr && (sfr_addr == `MTOS_ADDR_CONF);
	assign wr_ovf_low  = sfr_wr && (sfr_addr == `MTOS_ADDR_OVF_LOW);
	assign wr_ovf_mid  = sfr_wr && (sfr_addr == `MTOS_ADDR_OVF_MID);
	assign wr_ovf_high = sfr_wr && (sfr_addr == `MTOS_ADDR_OVF_HIGH);
	assign run_wr      = sfr_wdata[`MTOS_CONF_RUN];
	assign sync_wr     = sfr_wdata[`MTOS_CONF_SYNC];
	assign ovf_wval    = {sfr_wdata[3:0], stage_mid, stage_low};

	// counter core hookup
	assign tmr.run        = timer_running;
	assign tmr.halt       = count_halt;
	assign tmr.load       = load_now;
	assign tmr.load_value = div_rem[15:0];
	assign tmr.period     = timer_period;
	assign tmr.cmp_value  = byte_compare_value;
	assign tmr.cmp_sel    = compare_byte_select;
	assign timer_value    = tmr.value;

	mtos_counter u_counter (
		.clk    (clk),
		.resetn (resetn),
		.tmr    (tmr)
	);

	// sleep clock passes two flops before the edge detector
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sleep_ff1 <= 1'b0;
			sleep_ff2 <= 1'b0;
			sleep_ff3 <= 1'b0;
		end
		else
		begin
			sleep_ff1 <= sleep_clk;
			sleep_ff2 <= sleep_ff1;
			sleep_ff3 <= sleep_ff2;
		end
	end
	assign sleep_edge = sleep_ff2 && !sleep_ff3;

	// run state; stop_wait still counts, calc is still idle
	assign timer_running = (state == st_run) || (state == st_stop_wait);
	assign load_now = (state == st_calc) && (calc_cnt == SYNC_LAST);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			state <= st_idle;
		else
		begin
			unique case (state)
				st_idle:
					if (wr_conf && run_wr)
						state <= sync_wr ? st_start_wait : st_run;
				st_run:
					if (wr_conf && !run_wr)
						state <= sync_wr ? st_stop_wait : st_idle;
				// a config write in the edge cycle wins, so capture and state agree
				st_stop_wait:
					if (wr_conf && run_wr)
						state <= st_run;
					else if (wr_conf && !sync_wr)
						state <= st_idle;
					else if (sleep_edge && !wr_conf)
						state <= st_idle;
				st_start_wait:
					if (wr_conf && !run_wr)
						state <= st_idle;
					else if (wr_conf && !sync_wr)
						state <= st_run;
					else if (sleep_edge && !wr_conf)
						state <= st_calc;
				st_calc:
					if (load_now)
						state <= st_run;
			endcase
		end
	end

	// sleep count held at the stopping edge
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			sleep_stored <= '0;
		else if ((state == st_stop_wait) && sleep_edge && !wr_conf)
			sleep_stored <= sleep_count;
	end

	// reload pipeline: restoring divide by the period, one bit a cycle.
	// the two clocks beat at a non-integer ratio, so the edge-to-sample jitter
	// leaves up to one count of error; not corrected
	assign div_shift = {div_rem[15:0], div_quo[CALC_W-1]};

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			calc_cnt <= 7'h00;
			div_cnt  <= 6'h00;
			div_quo  <= '0;
			div_rem  <= 17'h00000;
		end
		else if ((state == st_start_wait) && sleep_edge && !wr_conf)
		begin
			calc_cnt <= 7'h00;
			div_cnt  <= 6'h00;
			div_quo  <= reload_sum(elapsed(sleep_count, sleep_stored), tmr.value);
			div_rem  <= 17'h00000;
		end
		else if (state == st_calc)
		begin
			calc_cnt <= calc_cnt + 7'h01;
			if (div_cnt != DIV_STEPS)
			begin
				div_cnt <= div_cnt + 6'h01;
				if (div_shift >= {1'b0, timer_period})
				begin
					div_rem <= div_shift - {1'b0, timer_period};
					div_quo <= {div_quo[CALC_W-2:0], 1'b1};
				end
				else
				begin
					div_rem <= div_shift;
					div_quo <= {div_quo[CALC_W-2:0], 1'b0};
				end
			end
		end
	end

	// staging bytes; the high byte write commits all three
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			stage_low <= 8'h00;
			stage_mid <= 8'h00;
		end
		else
		begin
			if (wr_ovf_low)
				stage_low <= sfr_wdata;
			if (wr_ovf_mid)
				stage_mid <= sfr_wdata;
		end
	end

	// overflow count and its one-shot extra increment
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ovf_count     <= 20'h00000;
			ovf_extra     <= 20'h00000;
			extra_pending <= 1'b0;
		end
		else if (load_now)
			ovf_count <= ovf_count + div_quo[19:0];
		else if (wr_ovf_high && !timer_running)
			ovf_count <= ovf_wval + 20'(tmr.ovf_evt);
		else if (wr_ovf_high && tmr.ovf_evt)
		begin
			ovf_count     <= ovf_count + 20'h00001 + ovf_wval;
			extra_pending <= 1'b0;
		end
		else if (wr_ovf_high)
		begin
			ovf_extra     <= ovf_wval;
			extra_pending <= 1'b1;
		end
		else if (tmr.ovf_evt)
		begin
			// extra applies to this overflow only, then back to one
			ovf_count     <= ovf_count + 20'h00001 + (extra_pending ? ovf_extra : 20'h00000);
			extra_pending <= 1'b0;
		end
	end

	// compare fires on entering the at-or-above region, so a cleared flag
	// stays clear while the count sits above the value
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			ovf_ge_q <= 1'b1;
		else
			ovf_ge_q <= (ovf_count >= ovf_compare);
	end
	assign ovf_cmp_evt = (ovf_count >= ovf_compare) && !ovf_ge_q;

	// configuration bits other than run
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			compare_byte_select <= 1'((`MTOS_CONF_RESET >> `MTOS_CONF_CMP_SEL) & 8'h01);
			conf_rsvd           <= 1'((`MTOS_CONF_RESET >> `MTOS_CONF_RSVD) & 8'h01);
			sync_mode           <= 1'((`MTOS_CONF_RESET >> `MTOS_CONF_SYNC) & 8'h01);
		end
		else if (wr_conf)
		begin
			compare_byte_select <= sfr_wdata[`MTOS_CONF_CMP_SEL];
			conf_rsvd           <= sfr_wdata[`MTOS_CONF_RSVD];
			sync_mode           <= sync_wr;
		end
	end

	// flags: event wins over a same-cycle clear; writing one leaves a flag alone
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			compare_flag     <= 1'b0;
			overflow_flag    <= 1'b0;
			ovf_compare_flag <= 1'b0;
		end
		else
		begin
			if (tmr.cmp_evt)
				compare_flag <= 1'b1;
			else if (wr_conf && !sfr_wdata[`MTOS_CONF_CMP_FLAG])
				compare_flag <= 1'b0;
			if (tmr.ovf_evt)
				overflow_flag <= 1'b1;
			else if (wr_conf && !sfr_wdata[`MTOS_CONF_OVF_FLAG])
				overflow_flag <= 1'b0;
			if (ovf_cmp_evt)
				ovf_compare_flag <= 1'b1;
			else if (wr_conf && !sfr_wdata[`MTOS_CONF_OCMP_FLAG])
				ovf_compare_flag <= 1'b0;
		end
	end

	// overflow compare value and the three masks
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ovf_compare        <= 20'h00000;
			byte_compare_value <= 8'h00;
			{mask_cmp, mask_ovf, ovf_compare_mask} <= `MTOS_MASKS_RESET;
		end
		else
		begin
			if (sfr_wr && (sfr_addr == `MTOS_ADDR_OCMP_LOW))
				ovf_compare[7:0] <= sfr_wdata;
			if (sfr_wr && (sfr_addr == `MTOS_ADDR_OCMP_MID))
				ovf_compare[15:8] <= sfr_wdata;
			if (sfr_wr && (sfr_addr == `MTOS_ADDR_OCMP_HIGH))
			begin
				ovf_compare[19:16] <= sfr_wdata[3:0];
				mask_cmp           <= sfr_wdata[`MTOS_MASK_CMP];
				mask_ovf           <= sfr_wdata[`MTOS_MASK_OVF];
				ovf_compare_mask   <= sfr_wdata[`MTOS_MASK_OCMP];
			end
			if (sfr_wr && (sfr_addr == `MTOS_ADDR_CMP_VAL))
				byte_compare_value <= sfr_wdata;
		end
	end

	// request is the masked or of the flags
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			timer_irq <= 1'b0;
		else
			timer_irq <= (compare_flag && mask_cmp) || (overflow_flag && mask_ovf)
				|| (ovf_compare_flag && ovf_compare_mask);
	end

	// dma triggers, one cycle per event
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dma_trigger_compare  <= 1'b0;
			dma_trigger_overflow <= 1'b0;
		end
		else
		begin
			dma_trigger_compare  <= tmr.cmp_evt;
			dma_trigger_overflow <= tmr.ovf_evt;
		end
	end

	// low byte read freezes the upper twelve bits
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			ovf_latch <= 12'h000;
		else if (sfr_rd && (sfr_addr == `MTOS_ADDR_OVF_LOW))
			ovf_latch <= ovf_count[19:8];
	end

	// read data registered, valid the cycle after the strobe
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			sfr_rdata <= 8'h00;
		else if (sfr_rd)
		begin
			unique case (sfr_addr)
				`MTOS_ADDR_CONF:
					sfr_rdata <= {compare_flag, overflow_flag, ovf_compare_flag, 1'b0,
						compare_byte_select, conf_rsvd, sync_mode, timer_running};
				`MTOS_ADDR_OVF_LOW:
					sfr_rdata <= ovf_count[7:0];
				`MTOS_ADDR_OVF_MID:
					sfr_rdata <= ovf_latch[7:0];
				`MTOS_ADDR_OVF_HIGH:
					sfr_rdata <= {4'h0, ovf_latch[11:8]};
				`MTOS_ADDR_CMP_VAL:
					sfr_rdata <= byte_compare_value;
				`MTOS_ADDR_OCMP_LOW:
					sfr_rdata <= ovf_compare[7:0];
				`MTOS_ADDR_OCMP_MID:
					sfr_rdata <= ovf_compare[15:8];
				`MTOS_ADDR_OCMP_HIGH:
					sfr_rdata <= {mask_cmp, mask_ovf, ovf_compare_mask, 1'b0,
						ovf_compare[19:16]};
				default:
					sfr_rdata <= 8'h00;
			endcase
		end
	end
endmodule // mtos_top

// *** verif/mtos_checker.sv ***
// port-level checks for the overflow/sync timer
// assumes bind onto mtos_top, one clock domain
`include "mtos_map.svh"

module mtos_checker
	import mtos_pkg::*;
(
	input wire logic                 clk,
	input wire logic                 resetn,
	input wire logic [7:0]           sfr_addr,
	input wire mtos_pkg::mtos_byte_t sfr_wdata,
	input wire logic                 sfr_wr,
	input wire logic                 sfr_rd,
	input wire mtos_pkg::mtos_byte_t sfr_rdata,
	input wire mtos_pkg::mtos_tval_t timer_period,
	input wire logic                 count_halt,
	input wire mtos_pkg::mtos_tval_t timer_value,
	input wire logic                 timer_running,
	input wire logic                 dma_trigger_compare,
	input wire logic                 dma_trigger_overflow
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic        cw;
	logic        cr;
	logic        step;
	logic [16:0] nxt;
	assign cw = sfr_wr && sfr_addr == `MTOS_ADDR_CONF;
	assign cr = sfr_rd && sfr_addr == `MTOS_ADDR_CONF;
	// writes may change the run state, so write cycles are skipped and only quiet cycles are judged
	assign step = timer_running && !count_halt && !sfr_wr;
	assign nxt = {1'b0, timer_value} + 17'h1;
	sequence s_wrap;
		step && nxt >= {1'b0, timer_period} ##1 timer_running;
	endsequence
	sequence s_step;
		step && nxt < {1'b0, timer_period} ##1 timer_running;
	endsequence
	sequence s_keep;
		timer_running ##1 timer_running;
	endsequence
	ovf_pulse_a: assert property (dma_trigger_overflow |=> !dma_trigger_overflow)
		else $error("overflow trigger longer than one cycle");
	cmp_pulse_a: assert property (dma_trigger_compare |=> !dma_trigger_compare)
		else $error("compare trigger longer than one cycle");
	ovf_fire_a: assert property (s_wrap |-> dma_trigger_overflow)
		else $error("overflow without trigger");
	ovf_wrap_a: assert property (s_wrap |->
		timer_value == mtos_tval_t'($past(nxt) - {1'b0, $past(timer_period)}))
		else $error("wrap value wrong");
	count_step_a: assert property (s_step |-> timer_value == $past(timer_value) + 16'h1)
		else $error("count step wrong");
	zero_bit_a: assert property (cr |=> sfr_rdata[4] == 1'b0)
		else $error("config bit 4 not zero");
	run_read_a: assert property (cr |=> sfr_rdata[0] == $past(timer_running))
		else $error("run bit not actual state");
	fast_start_a: assert property (cw && sfr_wdata[1:0] == 2'b01 |=> timer_running)
		else $error("immediate start missed");
	fast_stop_a: assert property (cw && sfr_wdata[1:0] == 2'b00 |=> !timer_running)
		else $error("immediate stop missed");
	sync_hold_a: assert property (cw && sfr_wdata[1:0] == 2'b10 && timer_running |-> s_keep)
		else $error("sync stop not deferred");
	sync_wait_a: assert property (cw && sfr_wdata[1:0] == 2'b11 && !timer_running
		|=> !timer_running [*8])
		else $error("sync start not deferred");
endmodule // mtos_checker

bind mtos_top mtos_checker u_chk (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
	.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
	.timer_period(timer_period), .count_halt(count_halt), .timer_value(timer_value),
	.timer_running(timer_running), .dma_trigger_compare(dma_trigger_compare),
	.dma_trigger_overflow(dma_trigger_overflow));

// *** verif/mtos_cpu_model.sv ***
// processor-side model issuing one-cycle register strobes
// assumes strobes are sampled on the rising clock edge
module mtos_cpu_model
	import mtos_pkg::*;
(
	input  wire logic                 clk,
	input  wire mtos_pkg::mtos_byte_t sfr_rdata,
	output logic [7:0]                sfr_addr,
	output mtos_pkg::mtos_byte_t      sfr_wdata,
	output logic                      sfr_wr,
	output logic                      sfr_rd
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
	end
	// flags cleared only by config writes; callers keep bit 2 at 0
	// system clock assumed full rate before sync use
	task automatic wr(input logic [7:0] a, input mtos_byte_t d);
		@(posedge clk);
		#1;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk);
		#1;
		sfr_wr = 1'b0;
		// released bus shows junk, not the old value
		sfr_addr = ~a;
		sfr_wdata = ~d;
	endtask
	// callers read the low count byte before the others
	task automatic rd(input logic [7:0] a, output mtos_byte_t d);
		@(posedge clk);
		#1;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge clk);
		#1;
		d = sfr_rdata;
		sfr_rd = 1'b0;
		sfr_addr = ~a;
	endtask
endmodule // mtos_cpu_model

// *** verif/tb.sv ***
// self-checking bench for the overflow/sync timer
// assumes mtos_checker is bound and the cpu model drives the bus
`include "mtos_map.svh"

module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import mtos_pkg::*;
	logic        clk;
	logic        resetn;
	logic [7:0]  addr;
	mtos_byte_t  wdata;
	logic        wr;
	logic        rd;
	mtos_byte_t  rdata;
	mtos_tval_t  period;
	logic        halt;
	logic        slk;
	mtos_sleep_t scount;
	mtos_tval_t  tv;
	logic        run;
	logic        irq;
	logic        dov;
	logic        dcp;
	int          ncmp = 0;
	int          n_errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          srise = 0;
	int          sdiv = 0;
	mtos_byte_t  b;

	mtos_top DUT (.clk(clk), .resetn(resetn), .sfr_addr(addr), .sfr_wdata(wdata),
		.sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdata), .timer_period(period),
		.count_halt(halt), .sleep_clk(slk), .sleep_count(scount), .timer_value(tv),
		.timer_running(run), .timer_irq(irq), .dma_trigger_compare(dcp),
		.dma_trigger_overflow(dov));
	mtos_cpu_model cpu (.clk(clk), .sfr_rdata(rdata), .sfr_addr(addr),
		.sfr_wdata(wdata), .sfr_wr(wr), .sfr_rd(rd));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	// compare trigger pulses, counted at the edge after they rise
	always @(posedge clk) if (dcp === 1'b1) ncmp <= ncmp + 1;
	// sleep clock locked to clk so the start delay can be counted
	always @(posedge clk)
	begin
		#1;
		sdiv = (sdiv == 1525) ? 0 : sdiv + 1;
		if (sdiv == 0)
		begin
			slk = ~slk;
			scount = scount + {23'h0, slk};
			if (slk)
				srise = cyc;
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
		cmp_count++;
		if (s !== e)
		begin
			$display("[ERR] %s exp %h got %h", n, e, s);
			n_errors++;
		end
	endtask
	task automatic guard(inout int k);
		k++;
		if (k > 30000)
		begin
			n_errors++;
			results();
		end
	endtask
	task automatic conf(input mtos_byte_t e);
		cpu.rd(`MTOS_ADDR_CONF, b);
		check("conf", b, e);
	endtask
	task automatic rd_cnt(output logic [19:0] c);
		mtos_byte_t lo;
		mtos_byte_t mi;
		cpu.rd(`MTOS_ADDR_OVF_LOW, lo);
		cpu.rd(`MTOS_ADDR_OVF_MID, mi);
		cpu.rd(`MTOS_ADDR_OVF_HIGH, b);
		c = {b[3:0], mi, lo};
	endtask
	task automatic wr_cnt(input logic [19:0] v);
		cpu.wr(`MTOS_ADDR_OVF_LOW, v[7:0]);
		cpu.wr(`MTOS_ADDR_OVF_MID, v[15:8]);
		cpu.wr(`MTOS_ADDR_OVF_HIGH, {4'h0, v[19:16]});
	endtask
	task automatic pulses(input int n);
		int k;
		k = 0;
		while (n > 0)
		begin
			@(posedge clk);
			#1;
			if (dov === 1'b1)
				n--;
			guard(k);
		end
	endtask
	task automatic burst(input int n);
		halt = 1'b0;
		repeat (n) @(posedge clk);
		#1;
		halt = 1'b1;
	endtask

	task automatic t_reset();
		logic [19:0] c;
		conf(8'h02);
		rd_cnt(c);
		check("cnt_rst", c, 20'h0);
		$display("done reset");
	endtask
	task automatic t_count();
		logic [19:0] c;
		int          k;
		period = 16'h000a;
		cpu.wr(`MTOS_ADDR_CONF, 8'h00);
		wr_cnt(20'h12345);
		rd_cnt(c);
		check("idle_load", c, 20'h12345);
		cpu.wr(`MTOS_ADDR_CONF, 8'h01);
		conf(8'h01);
		wr_cnt(20'h00005);
		halt = 1'b0;
		pulses(2);
		halt = 1'b1;
		rd_cnt(c);
		check("run_add", c, 20'h1234c);
		conf(8'h41);
		check("irq_mask", irq, 1'b0);
		cpu.wr(`MTOS_ADDR_OCMP_HIGH, 8'h40);
		repeat (2) @(posedge clk);
		#1;
		check("irq_on", irq, 1'b1);
		cpu.wr(`MTOS_ADDR_CONF, 8'he1);
		conf(8'h41);
		cpu.wr(`MTOS_ADDR_CONF, 8'h01);
		conf(8'h01);
		check("irq_off", irq, 1'b0);
		cpu.wr(`MTOS_ADDR_CMP_VAL, 8'h05);
		cpu.wr(`MTOS_ADDR_CONF, 8'h09);
		k = ncmp;
		burst(25);
		conf(8'hc9);
		check("cmp_dma", 24'(ncmp - k), 24'h3);
		rd_cnt(c);
		c = c + 20'h2;
		cpu.wr(`MTOS_ADDR_OCMP_LOW, c[7:0]);
		cpu.wr(`MTOS_ADDR_OCMP_MID, c[15:8]);
		cpu.wr(`MTOS_ADDR_OCMP_HIGH, {4'h2, c[19:16]});
		burst(30);
		conf(8'he9);
		check("irq_ocmp", irq, 1'b1);
		cpu.wr(`MTOS_ADDR_CONF, 8'h01);
		burst(25);
		conf(8'h41);
		$display("done count");
	endtask
	// high byte write lands in the very cycle of an overflow
	task automatic t_coinc();
		logic [19:0] c;
		logic [19:0] c2;
		rd_cnt(c);
		burst(9);
		cpu.wr(`MTOS_ADDR_OVF_LOW, 8'h03);
		cpu.wr(`MTOS_ADDR_OVF_MID, 8'h00);
		fork
			cpu.wr(`MTOS_ADDR_OVF_HIGH, 8'h00);
			begin
				@(posedge clk);
				#1;
				halt = 1'b0;
			end
		join
		halt = 1'b1;
		rd_cnt(c2);
		check("wr_ovf", c2, c + 20'h4);
		burst(10);
		rd_cnt(c2);
		check("next_ovf", c2, c + 20'h5);
		$display("done coinc");
	endtask
	task automatic t_sync();
		logic [19:0] o;
		logic [19:0] c2;
		mtos_sleep_t ns;
		mtos_tval_t  tc;
		longint      cc;
		int          k;
		period = 16'd1000;
		halt = 1'b0;
		cpu.wr(`MTOS_ADDR_CONF, 8'h03);
		cpu.wr(`MTOS_ADDR_CONF, 8'h02);
		check("stop_wait", run, 1'b1);
		k = 0;
		while (run !== 1'b0)
		begin
			@(posedge clk);
			#1;
			guard(k);
		end
		ns = scount;
		tc = tv;
		rd_cnt(o);
		check("frozen", tv, tc);
		repeat (3000) @(posedge clk);
		cpu.wr(`MTOS_ADDR_CONF, 8'h03);
		check("start_wait", run, 1'b0);
		k = 0;
		while (run !== 1'b1)
		begin
			@(posedge clk);
			#1;
			guard(k);
		end
		// frozen so no overflow slips in while the count is read back
		halt = 1'b1;
		check("sync_dly", (cyc - srise) >= 76 && (cyc - srise) <= 78, 1'b1);
		// elapsed ticks times 976.5625 kept exact in sixteenths
		cc = (longint'(scount - ns) * 15625 + 16 * (tc + 75) + 8) / 16;
		k = int'(cc % 1000) - int'(tv);
		check("reload_t", k >= -1 && k <= 1, 1'b1);
		rd_cnt(c2);
		check("reload_o", c2, o + 20'(cc / 1000));
		$display("done sync");
	endtask

	initial
	begin
		resetn = 1'b0;
		period = 16'h000a;
		halt = 1'b1;
		slk = 1'b0;
		scount = 24'h000100;
		repeat (6) @(posedge clk);
		#1;
		resetn = 1'b1;
		t_reset();
		t_count();
		t_coinc();
		t_sync();
		results();
	end
endmodule // tb
